// ==== common/fsg_pkg.sv ====
// Constants and types shared by the flash section guard.
package fsg_pkg;
    localparam int ADDR_W = 15;
    localparam logic [2:0] ADR_CTRL = 3'h0;
    localparam logic [2:0] ADR_LOCK = 3'h1;
    localparam logic [2:0] ADR_STAT = 3'h2;
    localparam logic [14:0] HALT_BASE = 15'h3000;
    localparam logic [14:0] BOOT_BASE_3 = 15'h3E00;
    localparam logic [14:0] BOOT_BASE_2 = 15'h3C00;
    localparam logic [14:0] BOOT_BASE_1 = 15'h3800;
    localparam logic [14:0] BOOT_BASE_0 = 15'h3000;
    localparam logic [7:0] CMD_MASK = 8'h7F;
    localparam logic [7:0] CMD_ERASE = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h05;
    localparam logic [7:0] CMD_LOCK = 8'h09;
    localparam logic [7:0] CMD_REEN = 8'h11;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] LOCK_RST = 4'hF;
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam int PROG_TIME_NS = 4000;
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [15:0] PROG_CYCLES = 16'(PROG_TIME_NS / CLK_PERIOD_NS);
    localparam logic [15:0] CNT_RST = 16'h0000;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,
        ST_PROG = 3'h2,
        ST_DONE = 3'h4
    } fsg_state_t;
    typedef struct packed
    {
        fsg_state_t st;
        logic [7:0] cmd;
        logic [2:0] arm;
        logic [3:0] lock;
        logic [15:0] cnt;
        logic halt;
        logic busy;
        logic [7:0] rdata;
    } fsg_regs_t;
endpackage : fsg_pkg

// ==== hw/fsg_guard.sv ====
// Flash section guard: lock bits, read-while-write control and stall logic.
//
// Added by the designer: the placing of the registers and the strobed register port.
module fsg_guard
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] boot_size_fuses,
    input wire logic chip_erase,
    input wire logic [1:0] general_lock_mode,
    input wire logic vectors_in_boot,
    input wire logic [fsg_pkg::ADDR_W-1:0] exec_addr,
    input wire logic store_program_memory_op,
    input wire logic load_program_memory_op,
    input wire logic [fsg_pkg::ADDR_W-1:0] target_addr,
    output logic load_allowed,
    output logic prog_start,
    output logic cpu_stall,
    output logic concurrent_readable,
    output logic irq_disable,
    output logic concurrent_section_busy
);
    import fsg_pkg::*;

    fsg_regs_t r_reg;
    fsg_regs_t r_next;

    // Boot section start for a given fuse setting; even the largest size starts no lower than HALT_BASE.
    function automatic logic [ADDR_W-1:0] boot_base(input logic [1:0] sz);
        case (sz)
            2'h3: boot_base = BOOT_BASE_3;
            2'h2: boot_base = BOOT_BASE_2;
            2'h1: boot_base = BOOT_BASE_1;
            default: boot_base = BOOT_BASE_0;
        endcase
    endfunction : boot_base

    // A lock pair is {hi, lo} with 1 unprogrammed; a programmed low bit blocks stores.
    function automatic logic pair_wr_blk(input logic [1:0] pair);
        pair_wr_blk = ~pair[0];
    endfunction : pair_wr_blk

    // A programmed high bit blocks loads coming from the other section.
    function automatic logic pair_rd_blk(input logic [1:0] pair);
        pair_rd_blk = ~pair[1];
    endfunction : pair_rd_blk

    // Only the low seven bits select a command, so the top bit is ignored.
    function automatic logic cmd_is(input logic [7:0] cmd, input logic [7:0] code);
        cmd_is = (cmd & CMD_MASK) == code;
    endfunction : cmd_is

    logic exec_boot;
    logic tgt_boot;
    logic tgt_halt;
    logic app_wr_blk;
    logic app_rd_blk;
    logic boot_wr_blk;
    logic boot_rd_blk;
    logic wr_ok;
    logic cmd_prog;

    always_comb
    begin
        exec_boot = exec_addr >= boot_base(boot_size_fuses);
        tgt_boot = target_addr >= boot_base(boot_size_fuses);
        tgt_halt = target_addr >= HALT_BASE;
        // Lock bits: 1 is unprogrammed; general lock mode is deliberately not consulted.
        app_wr_blk = pair_wr_blk(r_reg.lock[3:2]);
        app_rd_blk = pair_rd_blk(r_reg.lock[3:2]);
        boot_wr_blk = pair_wr_blk(r_reg.lock[1:0]);
        boot_rd_blk = pair_rd_blk(r_reg.lock[1:0]);
        wr_ok = exec_boot & (tgt_boot ? ~boot_wr_blk : ~app_wr_blk);
        cmd_prog = cmd_is(r_reg.cmd, CMD_ERASE) | cmd_is(r_reg.cmd, CMD_WRITE);
    end

    always_comb
    begin
        r_next = r_reg;
        r_next.rdata = 8'h00;
        if (r_reg.arm != 3'h0)
        begin
            r_next.arm = r_reg.arm - 3'h1;
        end
        if (reg_rd)
        begin
            case (reg_addr)
                ADR_CTRL: r_next.rdata = r_reg.cmd;
                ADR_LOCK: r_next.rdata = {4'h0, r_reg.lock};
                ADR_STAT: r_next.rdata = {5'h00, r_reg.halt, r_reg.st == ST_PROG, r_reg.busy};
                default: r_next.rdata = 8'h00;
            endcase
        end
        if (reg_wr && reg_addr == ADR_CTRL && r_reg.st == ST_IDLE)
        begin
            r_next.cmd = reg_wdata;
            r_next.arm = ARM_CYCLES;
            if ((reg_wdata & CMD_MASK) == CMD_REEN && !r_reg.halt)
            begin
                r_next.busy = 1'b0;
                r_next.arm = 3'h0;
            end
        end
        case (r_reg.st)
            ST_IDLE:
            begin
                if (store_program_memory_op && r_reg.arm != 3'h0 && exec_boot)
                begin
                    r_next.arm = 3'h0;
                    if ((r_reg.cmd & CMD_MASK) == CMD_LOCK)
                    begin
                        r_next.lock = r_reg.lock & reg_wdata[3:0];
                    end
                    else if (cmd_prog && wr_ok)
                    begin
                        r_next.st = ST_PROG;
                        r_next.cnt = PROG_CYCLES;
                        r_next.halt = tgt_halt;
                        r_next.busy = 1'b1;
                    end
                end
            end
            ST_PROG:
            begin
                r_next.cnt = r_reg.cnt - 16'h0001;
                if (r_reg.cnt == 16'h0001)
                begin
                    r_next.st = ST_DONE;
                end
            end
            ST_DONE:
            begin
                r_next.st = ST_IDLE;
                r_next.halt = 1'b0;
                r_next.cmd = CTRL_RST;
            end
            default: r_next.st = ST_IDLE;
        endcase
        if (chip_erase)
        begin
            r_next.lock = LOCK_RST;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            r_reg <= '{st: ST_IDLE, cmd: CTRL_RST, arm: 3'h0, lock: LOCK_RST, cnt: CNT_RST,
                       halt: 1'b0, busy: 1'b0, rdata: 8'h00};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    logic prog_go;
    assign prog_go = r_reg.st == ST_IDLE && r_next.st == ST_PROG;
    assign prog_start = prog_go;
    assign reg_rdata = r_reg.rdata;
    assign cpu_stall = r_reg.halt;
    assign concurrent_section_busy = r_reg.busy;
    assign concurrent_readable = ~r_reg.busy;
    // Loads cross-section reads only; same-section reads are never blocked.
    assign load_allowed = load_program_memory_op &
        (exec_boot ? (tgt_boot | ~app_rd_blk) : (~tgt_boot | ~boot_rd_blk));
    assign irq_disable = exec_boot ? (~vectors_in_boot & ~r_reg.lock[1])
                                   : (vectors_in_boot & ~r_reg.lock[3]);

    logic unused_gl;
    assign unused_gl = ^general_lock_mode;

    // Building blocks for the multi-cycle checks below.
    sequence s_store_armed;
        store_program_memory_op && r_reg.arm != 3'h0 && r_reg.st == ST_IDLE;
    endsequence : s_store_armed

    sequence s_prog_run;
        (r_reg.st == ST_PROG) [*8];
    endsequence : s_prog_run

    sequence s_stall_run;
        cpu_stall [*8];
    endsequence : s_stall_run

    sequence s_reen_write;
        reg_wr && reg_addr == ADR_CTRL && cmd_is(reg_wdata, CMD_REEN);
    endsequence : s_reen_write

    // Section, start and stall checks.
    AST_APP_STORE_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        !exec_boot |-> !prog_start)
        else $error("store from application started programming");

    AST_ARMED_START: assert property (@(posedge sys_clk) disable iff (rst)
        s_store_armed ##0 (cmd_prog && wr_ok) |-> prog_start)
        else $error("permitted store did not start programming");

    AST_BOOT_INSIDE_HALT: assert property (@(posedge sys_clk) disable iff (rst)
        boot_base(boot_size_fuses) >= HALT_BASE)
        else $error("boot section reaches into concurrent section");

    AST_RWW_RUNS: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start && !tgt_halt |=> !cpu_stall)
        else $error("concurrent program stalled");

    AST_HALT_STALLS: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start && tgt_halt |=> s_stall_run)
        else $error("halting program not stalled");

    AST_HALT_BY_TARGET: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start |=> cpu_stall == $past(tgt_halt))
        else $error("stall does not follow target section");

    AST_STALL_ONLY_PROG: assert property (@(posedge sys_clk) disable iff (rst)
        cpu_stall |-> r_reg.st == ST_PROG || r_reg.st == ST_DONE)
        else $error("stall outside programming");

    AST_STALL_END: assert property (@(posedge sys_clk) disable iff (rst)
        r_reg.st == ST_DONE |=> !cpu_stall)
        else $error("stall held after programming");

    // Busy flag checks.
    AST_BUSY_SET: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start |=> concurrent_section_busy)
        else $error("busy not set");

    AST_BUSY_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        r_reg.st == ST_PROG |-> concurrent_section_busy)
        else $error("busy dropped in programming");

    AST_BUSY_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
        concurrent_section_busy && !(reg_wr && reg_addr == ADR_CTRL && cmd_is(reg_wdata, CMD_REEN))
        |=> concurrent_section_busy)
        else $error("busy cleared without reenable");

    AST_STAT_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == ADR_STAT |=> reg_rdata[0] == $past(concurrent_section_busy))
        else $error("status read shows wrong busy");

    AST_REEN: assert property (@(posedge sys_clk) disable iff (rst)
        s_reen_write ##0 (r_reg.st == ST_IDLE && !chip_erase && !prog_start) |=> !concurrent_section_busy)
        else $error("reenable did not clear busy");

    // Lock pair checks.
    AST_APP_WLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start && !tgt_boot |-> r_reg.lock[2])
        else $error("app lock bypassed");

    AST_BOOT_WLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start && tgt_boot |-> r_reg.lock[0])
        else $error("boot lock bypassed");

    AST_APP_RLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        load_allowed && exec_boot && !tgt_boot |-> r_reg.lock[3])
        else $error("app read lock bypassed");

    AST_BOOT_RLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        load_allowed && !exec_boot && tgt_boot |-> r_reg.lock[1])
        else $error("boot read lock bypassed");

    AST_SAME_SECTION_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
        load_program_memory_op && exec_boot == tgt_boot |-> load_allowed)
        else $error("same-section load refused");

    AST_LOCK_ONEWAY: assert property (@(posedge sys_clk) disable iff (rst)
        !chip_erase |=> (r_reg.lock & ~$past(r_reg.lock)) == 4'h0)
        else $error("lock bit unprogrammed");

    AST_LOCK_CMD: assert property (@(posedge sys_clk) disable iff (rst)
        s_store_armed ##0 (exec_boot && cmd_is(r_reg.cmd, CMD_LOCK) && !chip_erase)
        |=> r_reg.lock == ($past(r_reg.lock) & $past(reg_wdata[3:0])))
        else $error("lock command did not program pairs");

    AST_CHIP_ERASE: assert property (@(posedge sys_clk) disable iff (rst)
        chip_erase |=> r_reg.lock == LOCK_RST)
        else $error("chip erase did not clear lock bits");

    // Interrupt masking checks.
    AST_IRQ_APP: assert property (@(posedge sys_clk) disable iff (rst)
        !exec_boot && vectors_in_boot && !r_reg.lock[3] |-> irq_disable)
        else $error("interrupts live in locked application");

    AST_IRQ_BOOT: assert property (@(posedge sys_clk) disable iff (rst)
        exec_boot && !vectors_in_boot && !r_reg.lock[1] |-> irq_disable)
        else $error("interrupts live in locked boot");

    AST_IRQ_CAUSE: assert property (@(posedge sys_clk) disable iff (rst)
        irq_disable |-> (exec_boot ? (!r_reg.lock[1] && !vectors_in_boot) : (!r_reg.lock[3] && vectors_in_boot)))
        else $error("interrupts masked without cause");

    // Window, refusal and programming-length checks.
    AST_UNARMED_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        store_program_memory_op && r_reg.arm == 3'h0 |-> !prog_start)
        else $error("store outside window started programming");

    AST_NEED_CMD: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start |-> cmd_prog && wr_ok)
        else $error("programming started without permission");

    AST_LOAD_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
        load_allowed |-> load_program_memory_op)
        else $error("load allowed with no load");

    AST_PROG_LEN: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start |=> s_prog_run)
        else $error("programming ended early");

    AST_PROG_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
        prog_start |=> r_reg.cnt == PROG_CYCLES)
        else $error("programming counter not loaded");

    AST_PROG_COUNT: assert property (@(posedge sys_clk) disable iff (rst)
        r_reg.st == ST_PROG && r_reg.cnt != 16'h0001 |=> r_reg.st == ST_PROG)
        else $error("programming left before count ran out");

    AST_PROG_DONE: assert property (@(posedge sys_clk) disable iff (rst)
        r_reg.st == ST_PROG && r_reg.cnt == 16'h0001 |=> r_reg.st == ST_DONE)
        else $error("programming overran its count");

    AST_CTRL_LOCKOUT: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == ADR_CTRL && r_reg.st == ST_PROG |=> r_reg.cmd == $past(r_reg.cmd))
        else $error("command changed during programming");
endmodule : fsg_guard

// ==== test/fsg_cpu_model.sv ====
// CPU core model that issues program-memory loads and stores to the guard.
module fsg_cpu_model
(
    input wire logic sys_clk,
    input wire logic prog_start,
    input wire logic load_allowed,
    input wire logic busy,
    output logic [fsg_pkg::ADDR_W-1:0] exec_addr = '0,
    output logic [fsg_pkg::ADDR_W-1:0] target_addr = '0,
    output logic store_op = 1'b0,
    output logic load_op = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    import fsg_pkg::*;
    // One pulse; the caller has written the command in the cycle before.
    task automatic op(input logic st, input logic ld, input logic [14:0] e, input logic [14:0] t,
        output logic [7:0] res);
        exec_addr <= e;
        target_addr <= t;
        store_op <= st;
        load_op <= ld && !(busy && t < HALT_BASE);
        #1;
        res = {6'h00, load_allowed, prog_start};
        @(posedge sys_clk);
        store_op <= 1'b0;
        load_op <= 1'b0;
        target_addr <= ~t;
    endtask : op
endmodule : fsg_cpu_model

// ==== test/fsg_guard_tb_top.sv ====
// Self-checking bench for the flash section guard.
module fsg_guard_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fsg_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] fuses = 2'h3;
    logic chip_erase = 1'b0;
    logic [1:0] gen_lock = 2'h3;
    logic vec_boot = 1'b1;
    logic [7:0] reg_rdata, res;
    logic [14:0] exec_addr, target_addr;
    logic store_op, load_op, load_allowed, prog_start, cpu_stall, readable, irq_disable, busy;
    int num_errors = 0;
    int samples_checked = 0;
    int n;
    always #10 sys_clk = ~sys_clk;
    fsg_guard i_dut(.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_size_fuses(fuses),
        .chip_erase(chip_erase), .general_lock_mode(gen_lock), .vectors_in_boot(vec_boot),
        .exec_addr(exec_addr), .store_program_memory_op(store_op), .load_program_memory_op(load_op),
        .target_addr(target_addr), .load_allowed(load_allowed), .prog_start(prog_start),
        .cpu_stall(cpu_stall), .concurrent_readable(readable), .irq_disable(irq_disable),
        .concurrent_section_busy(busy));
    fsg_cpu_model i_cpu(.sys_clk(sys_clk), .prog_start(prog_start), .load_allowed(load_allowed),
        .busy(busy), .exec_addr(exec_addr), .target_addr(target_addr), .store_op(store_op),
        .load_op(load_op));
    task automatic finish_test;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    // Command write then store; the data lines carry the lock value in the store cycle.
    task automatic cmd(input logic [7:0] c, input logic [14:0] e, input logic [14:0] t, input logic [7:0] d);
        wr(ADR_CTRL, c);
        reg_wdata <= d;
        i_cpu.op(1'b1, 1'b0, e, t, res);
    endtask : cmd
    // Waits for {stall, busy, readable}; a hang ends the run.
    task automatic wait_for(input logic [7:0] exp);
        #1;
        for (n = 0; n < 300 && {5'h00, cpu_stall, busy, readable} !== exp; n++)
        begin
            @(posedge sys_clk);
            #1;
        end
        chk({5'h00, cpu_stall, busy, readable}, exp);
        if (n == 300)
            finish_test();
    endtask : wait_for
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ADR_STAT, 8'h00);
        rd(ADR_LOCK, 8'h0F);
        cmd(CMD_ERASE, 15'h0100, 15'h0200, 8'h00);
        chk(res, 8'h00);
        cmd(CMD_ERASE, 15'h3100, 15'h0200, 8'h00);
        chk(res, 8'h00);
        fuses <= 2'h0;
        gen_lock <= 2'h0;
        cmd(CMD_ERASE, 15'h3100, 15'h0200, 8'h00);
        chk(res, 8'h01);
        wait_for(8'h02);
        i_cpu.op(1'b0, 1'b1, 15'h3F00, 15'h3E10, res);
        chk(res, 8'h02);
        rd(ADR_STAT, 8'h03);
        repeat (205) @(posedge sys_clk);
        wait_for(8'h02);
        cmd(CMD_REEN, 15'h3F00, 15'h0000, 8'h00);
        wait_for(8'h01);
        cmd(CMD_WRITE, 15'h3F00, 15'h3E40, 8'h00);
        chk(res, 8'h01);
        repeat (100) @(posedge sys_clk);
        wait_for(8'h06);
        rd(ADR_STAT, 8'h07);
        wait_for(8'h02);
        cmd(CMD_REEN, 15'h3F00, 15'h0000, 8'h00);
        wait_for(8'h01);
        wr(ADR_CTRL, CMD_ERASE);
        repeat (4) @(posedge sys_clk);
        i_cpu.op(1'b1, 1'b0, 15'h3F00, 15'h0200, res);
        chk(res, 8'h00);
        cmd(CMD_LOCK, 15'h3F00, 15'h0000, 8'h0B);
        rd(ADR_LOCK, 8'h0B);
        cmd(CMD_ERASE, 15'h3F00, 15'h0200, 8'h00);
        chk(res, 8'h00);
        rd(ADR_STAT, 8'h00);
        i_cpu.op(1'b0, 1'b1, 15'h3F00, 15'h0200, res);
        chk(res, 8'h02);
        cmd(CMD_LOCK, 15'h3F00, 15'h0000, 8'h03);
        i_cpu.op(1'b0, 1'b1, 15'h3F00, 15'h0200, res);
        chk(res, 8'h00);
        i_cpu.op(1'b0, 1'b0, 15'h0100, 15'h0000, res);
        chk({7'h00, irq_disable}, 8'h01);
        cmd(CMD_LOCK, 15'h3F00, 15'h0000, 8'h00);
        rd(ADR_LOCK, 8'h00);
        cmd(CMD_WRITE, 15'h3F00, 15'h3E40, 8'h00);
        chk(res, 8'h00);
        i_cpu.op(1'b0, 1'b1, 15'h0100, 15'h3E40, res);
        chk(res, 8'h00);
        vec_boot <= 1'b0;
        i_cpu.op(1'b0, 1'b0, 15'h3F00, 15'h0000, res);
        chk({7'h00, irq_disable}, 8'h01);
        chip_erase <= 1'b1;
        @(posedge sys_clk);
        chip_erase <= 1'b0;
        rd(ADR_LOCK, 8'h0F);
        finish_test();
    end
endmodule : fsg_guard_tb_top
